// [logic/adc_pkg.sv]
/*
 package for the converter back end and its host reader.
 assumes one system clock shared by both ends.
*/
package adc_pkg;
  localparam int unsigned SAMPLE_W        = 16;
  localparam int unsigned DECIM_SLOW      = 8;
  localparam int unsigned DECIM_FAST      = 4;
  localparam int unsigned IMPULSE_PEAK_P  = 26;
  localparam int unsigned STEP_SETTLE_P   = 13;
  localparam int unsigned PWRUP_WAIT_P    = 100;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned CNT_W           = 8;
  // host register offsets
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_MASK        = 4'h2;
  localparam logic [3:0]  REG_SAMPLE      = 4'h3;
  localparam logic [3:0]  REG_COUNT       = 4'h4;
  // ctrl bits
  localparam int unsigned CTRL_DECIM_BIT  = 0;
  localparam int unsigned CTRL_RUN_BIT    = 1;
  // status bits
  localparam int unsigned ST_SAMPLE_BIT   = 0;
  localparam int unsigned ST_VALID_BIT    = 1;
  localparam int unsigned ST_OVERRUN_BIT  = 2;
  localparam logic [2:0]  ST_RESET        = 3'h0;
  localparam logic [2:0]  MASK_RESET      = 3'h0;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
endpackage

// [logic/adc_link_if.sv]
/*
 link between converter back end and host reader.
 the host reader takes the sample bus only while the enable is set.
*/
`timescale 1ns/1ns
interface adc_link_if;
  import adc_pkg::*;
  logic                decimation_select;
  logic                power_down_n;
  logic                sample_ready_n;
  logic                host_chip_enable_n;
  logic                rd_n;
  logic [SAMPLE_W-1:0] dout;
  logic                dout_oe;
  modport dev
  (
    input  decimation_select, power_down_n, host_chip_enable_n, rd_n,
    output sample_ready_n, dout, dout_oe
  );
  modport host
  (
    output decimation_select, power_down_n, host_chip_enable_n, rd_n,
    input  sample_ready_n, dout, dout_oe
  );
endinterface

// [logic/adc_decim.sv]
/*
 decimating averager: sums a window of modulator words.
 assumes the modulator word arrives every clock.
*/
`timescale 1ns/1ns
module adc_decim
  import adc_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire logic                i_run,
  input  wire logic                i_fast,
  input  wire logic [SAMPLE_W-1:0] i_mod,
  output logic                     o_strobe,
  output logic [SAMPLE_W-1:0]      o_word
);
  logic [3:0]            phase;
  logic [SAMPLE_W+2:0]   acc;
  logic [SAMPLE_W+2:0]   sum_in;
  wire  logic [3:0]      last_phase;
  wire  logic            at_end;

  assign last_phase = i_fast ? 4'(DECIM_FAST - 1) : 4'(DECIM_SLOW - 1);
  assign at_end     = (phase >= last_phase);
  assign sum_in     = acc + {{3{i_mod[SAMPLE_W-1]}}, i_mod};

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      phase    <= 4'h0;
      acc      <= '0;
      o_strobe <= 1'b0;
      o_word   <= '0;
    end
    else if (!i_run)
    begin
      phase    <= 4'h0;
      acc      <= '0;
      o_strobe <= 1'b0;
    end
    else
    begin
      o_strobe <= at_end;
      if (at_end)
      begin
        phase  <= 4'h0;
        acc    <= '0;
        o_word <= i_fast ? SAMPLE_W'(sum_in >>> 2) : SAMPLE_W'(sum_in >>> 3);
      end
      else
      begin
        phase <= phase + 4'h1;
        acc   <= sum_in;
      end
    end
  end
endmodule

// [logic/adc_dev.sv]
/*
 converter back end: decimation, power down, sample bus.
 assumes pins come from outside and are synchronised here.
*/
`timescale 1ns/1ns
module adc_dev
  import adc_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire logic [SAMPLE_W-1:0] i_mod,
  adc_link_if.dev                  link
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [1:0] sel_sync;
  logic [1:0] pd_sync;
  logic [1:0] ce_sync;
  logic [1:0] rd_sync;
  wire  logic sel_in;
  wire  logic pd_in;

  // undriven select and power-down pins resolve to defaults
  assign sel_in = (link.decimation_select === 1'b1);
  assign pd_in  = (link.power_down_n !== 1'b0);

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sel_sync <= 2'b00;
      pd_sync  <= 2'b11;
      ce_sync  <= 2'b11;
      rd_sync  <= 2'b11;
    end
    else
    begin
      sel_sync <= {sel_sync[0], sel_in};
      pd_sync  <= {pd_sync[0], pd_in};
      ce_sync  <= {ce_sync[0], link.host_chip_enable_n};
      rd_sync  <= {rd_sync[0], link.rd_n};
    end
  end

  // ---------------------------------------------
  // filter and word output
  // ---------------------------------------------
  wire  logic                run;
  wire  logic                strobe;
  wire  logic [SAMPLE_W-1:0] word;
  logic [SAMPLE_W-1:0]       dout;
  logic                      ready_n;

  assign run = pd_sync[1];

  // window length in clocks sets rate and latency
  adc_decim u_decim
  (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_run    (run),
    .i_fast   (sel_sync[1]),
    .i_mod    (i_mod),
    .o_strobe (strobe),
    .o_word   (word)
  );

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dout    <= '0;
      ready_n <= 1'b1;
    end
    else if (!run)
    begin
      dout    <= '0;
      ready_n <= 1'b1;
    end
    else if (strobe)
    begin
      dout    <= word;
      ready_n <= 1'b0;
    end
    else
    begin
      ready_n <= 1'b1;
    end
  end

  // ---------------------------------------------
  // sample bus
  // ---------------------------------------------
  assign link.sample_ready_n = ready_n;
  assign link.dout           = dout;
  assign link.dout_oe        = run && !ce_sync[1] && !rd_sync[1];
endmodule

// [logic/adc_host.sv]
/*
 host reader: registers, ready interrupt, 16-bit bus read.
 assumes the device shares the clock.
*/
`timescale 1ns/1ns
module adc_host
  import adc_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire logic [3:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic [31:0]              o_rdata,
  output logic                     o_irq,
  adc_link_if.host                 link
);
  logic [1:0]          ctrl;
  logic [2:0]          status;
  logic [2:0]          mask;
  logic [SAMPLE_W-1:0] sample;
  logic [CNT_W-1:0]    settle_cnt;
  logic [1:0]          rdy_sync;
  logic                rdy_prev;
  logic [1:0]          rd_phase;
  wire  logic          rdy_fall;
  wire  logic [2:0]    ev;
  wire  logic          valid;

  // ready falling edge starts the bus read; the sample event is set at read step 3
  assign rdy_fall = rdy_prev && !rdy_sync[1];
  assign valid    = (settle_cnt >= CNT_W'(PWRUP_WAIT_P));
  assign ev[ST_SAMPLE_BIT]  = rd_phase == 2'd3 && link.dout_oe && valid;
  assign ev[ST_VALID_BIT]   = rdy_fall && settle_cnt == CNT_W'(PWRUP_WAIT_P - 1);
  assign ev[ST_OVERRUN_BIT] = rdy_fall && rd_phase != 2'd0;

  assign link.decimation_select   = ctrl[CTRL_DECIM_BIT];
  assign link.power_down_n        = ctrl[CTRL_RUN_BIT];
  assign link.host_chip_enable_n  = (rd_phase == 2'd0);
  assign link.rd_n                = (rd_phase == 2'd0);
  assign o_irq = |(status & mask);

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl       <= CTRL_RESET;
      status     <= ST_RESET;
      mask       <= MASK_RESET;
      sample     <= '0;
      settle_cnt <= '0;
      rdy_sync   <= 2'b11;
      rdy_prev   <= 1'b1;
      rd_phase   <= 2'd0;
      o_rdata    <= '0;
    end
    else
    begin
      rdy_sync <= {rdy_sync[0], link.sample_ready_n};
      rdy_prev <= rdy_sync[1];
      // bus read held long enough to pass device synchronisers
      if (rdy_fall && rd_phase == 2'd0)
        rd_phase <= 2'd1;
      else if (rd_phase != 2'd0)
        rd_phase <= rd_phase + 2'd1;
      // take the word only while the device drives the bus
      if (rd_phase == 2'd3 && link.dout_oe)
        sample <= link.dout;
      if (!ctrl[CTRL_RUN_BIT])
        settle_cnt <= '0;
      else if (rdy_fall && !valid)
        settle_cnt <= settle_cnt + CNT_W'(1);
      status <= ev | (status & ~((i_wr && i_addr == REG_STATUS) ? i_wdata[2:0] : 3'h0));
      if (i_wr && i_addr == REG_CTRL)
        ctrl <= i_wdata[1:0];
      if (i_wr && i_addr == REG_MASK)
        mask <= i_wdata[2:0];
      o_rdata <= '0;
      if (i_rd)
      begin
        unique case (i_addr)
          REG_CTRL:   o_rdata <= {30'h0, ctrl};
          REG_STATUS: o_rdata <= {29'h0, status};
          REG_MASK:   o_rdata <= {29'h0, mask};
          REG_SAMPLE: o_rdata <= {16'h0, sample};
          REG_COUNT:  o_rdata <= {24'h0, settle_cnt};
          default:    o_rdata <= '0;
        endcase
      end
    end
  end
endmodule

// [tb/adc_link_props.sv]
/*
 assertions on the link between back end and host reader.
 assumes one clock and an async low reset.
*/
`timescale 1ns/1ns
module adc_link_props
  import adc_pkg::*;
(
  input wire logic                i_mclk,
  input wire logic                i_arst_n,
  input wire logic                decimation_select,
  input wire logic                power_down_n,
  input wire logic                sample_ready_n,
  input wire logic                host_chip_enable_n,
  input wire logic                rd_n,
  input wire logic [SAMPLE_W-1:0] dout,
  input wire logic                dout_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------
  // read access steps
  // ----------------------------
  sequence s_rd3;
    (!host_chip_enable_n && !rd_n) [*3];
  endsequence
  a_ready_pulse: assert property ($fell(sample_ready_n) |=> sample_ready_n)
    else $error("ready low longer than one cycle");
  a_period_slow: assert property ($fell(sample_ready_n) && $past(!decimation_select, 3)
    ##0 (!decimation_select && power_down_n) [*8] |=> $fell(sample_ready_n))
    else $error("word period not 8");
  a_period_fast: assert property ($fell(sample_ready_n) && $past(decimation_select, 3)
    ##0 (decimation_select && power_down_n) [*4] |=> $fell(sample_ready_n))
    else $error("word period not 4");
  a_bus_enable: assert property (dout_oe |-> $past(!host_chip_enable_n && !rd_n, 2))
    else $error("bus driven without select and read");
  a_pd_quiet: assert property (!power_down_n [*4] |-> sample_ready_n && !dout_oe)
    else $error("activity during power down");
  a_word_hold: assert property (!$fell(sample_ready_n) && power_down_n && $past(power_down_n, 4)
    |-> $stable(dout))
    else $error("word changed without ready");
  a_read_follow: assert property ($fell(sample_ready_n) |-> ##[2:5] s_rd3)
    else $error("no read after ready");
  a_read_width: assert property ($fell(host_chip_enable_n) |-> s_rd3 ##1 host_chip_enable_n)
    else $error("read access not 3 cycles");
endmodule

// [tb/adc_decimation_output_control_test.sv]
/*
 bench for the back end and host reader joined by the link.
 assumes package, interface and checker compiled first.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adc_decimation_output_control_test;
  import adc_pkg::*;
  logic                i_mclk     = 1'b0;
  logic                i_arst_n   = 1'b0;
  logic [SAMPLE_W-1:0] i_mod      = 16'h0123;
  logic [3:0]          i_addr     = 4'h0;
  logic [31:0]         i_wdata    = 32'h0;
  logic                i_wr       = 1'b0;
  logic                i_rd       = 1'b0;
  logic [31:0]         o_rdata;
  logic                o_irq;
  int                  num_errors = 0;
  int                  n_compared = 0;
  int                  cyc        = 0;
  int                  t0;
  adc_link_if lk();
  adc_dev u_adc_dev (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_mod(i_mod), .link(lk));
  adc_host u_adc_host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .link(lk));
  adc_link_props u_adc_link_props (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .decimation_select(lk.decimation_select), .power_down_n(lk.power_down_n),
    .sample_ready_n(lk.sample_ready_n), .host_chip_enable_n(lk.host_chip_enable_n),
    .rd_n(lk.rd_n), .dout(lk.dout), .dout_oe(lk.dout_oe));
  always #20 i_mclk = ~i_mclk;
  // ----------------------------
  // tasks
  // ----------------------------
  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    `CHK(n, e, o_rdata)
  endtask
  task automatic per(input int e, input string n);
    @(negedge lk.sample_ready_n);
    #1;
    t0 = cyc;
    @(negedge lk.sample_ready_n);
    #1;
    `CHK(n, e, cyc - t0)
  endtask
  // ----------------------------
  // timeout and tests
  // ----------------------------
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    rd(REG_CTRL, 32'h0, "ctrl");
    rd(REG_STATUS, 32'h0, "status");
    rd(REG_MASK, 32'h0, "mask");
    rd(4'hF, 32'h0, "unmapped");
    wr(REG_CTRL, 32'h2);
    per(DECIM_SLOW, "period by 8");
    repeat (20) @(negedge lk.sample_ready_n);
    rd(REG_SAMPLE, 32'h0123, "sample");
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h3);
    repeat (2) @(negedge lk.sample_ready_n);
    per(DECIM_FAST, "period by 4");
    repeat (PWRUP_WAIT_P) @(negedge lk.sample_ready_n);
    #1;
    `CHK("irq set", 1'b1, o_irq)
    rd(REG_COUNT, 32'(PWRUP_WAIT_P), "count");
    rd(REG_STATUS, 32'h3, "status settled");
    rd(REG_SAMPLE, 32'h0123, "sample fast");
    wr(REG_MASK, 32'h0);
    #1;
    `CHK("irq masked", 1'b0, o_irq)
    wr(REG_CTRL, 32'h0);
    repeat (10) @(posedge i_mclk);
    wr(REG_STATUS, 32'h7);
    rd(REG_STATUS, 32'h0, "status cleared");
    rd(REG_COUNT, 32'h0, "count cleared");
    `CHK("ready idle", 1'b1, lk.sample_ready_n)
    `CHK("bus idle", 1'b0, lk.dout_oe)
    wrap_up();
  end
endmodule
